// ==== ioexc_pkg.sv ====
// ioexc_pkg: register map, field layout and encodings of the expander control
// assumes a 32-bit apb slave on a single 50 mhz clock
package ioexc_pkg;
    localparam logic [11:0] INTF_OFS     = 12'h350;
    localparam logic [11:0] ADDR_LO_OFS  = 12'h354;
    localparam logic [11:0] ADDR_HI_OFS  = 12'h358;
    localparam logic [11:0] IRQ_STS_OFS  = 12'h35c;
    localparam logic [11:0] IRQ_MSK_OFS  = 12'h360;
    localparam int DATA_LSB   = 0;
    localparam int DATA_W     = 16;
    localparam int RELOAD_BIT = 24;
    localparam int TM_BIT     = 25;
    localparam int SEL_LSB    = 26;
    localparam int SEL_W      = 4;
    localparam int DONE_BIT   = 31;
    localparam int IRQ_BIT    = 0;
    localparam int ADDR_W     = 7;
    localparam int A0_LSB     = 1;
    localparam int A1_LSB     = 9;
    localparam int A2_LSB     = 17;
    localparam int A4_LSB     = 1;
    localparam int NEXP       = 4;
    localparam logic [3:0] SEL_E0 = 4'h0;
    localparam logic [3:0] SEL_E1 = 4'h1;
    localparam logic [3:0] SEL_E2 = 4'h2;
    localparam logic [3:0] SEL_E4 = 4'h4;
    localparam logic [1:0] OP_RELOAD = 2'h0;
    localparam logic [1:0] OP_WRITE  = 2'h1;
    localparam logic [1:0] OP_INIT   = 2'h2;
    typedef enum logic [2:0] {
        IOEXC_IDLE = 3'b001,
        IOEXC_REQ  = 3'b010,
        IOEXC_WAIT = 3'b100
    } ioexc_state_t;
endpackage : ioexc_pkg

// ==== ioexc_properties.sv ====
// ioexc_properties: port-level checks of the expander control
// assumes the apb master holds address and direction until pready
`timescale 1ns/1ps
module ioexc_properties #(
    parameter int DW = 16
) (
    input wire logic          sys_clk_i,
    input wire logic          arst_n_i,
    input wire logic          pwrite,
    input wire logic          pready,
    input wire logic [11:0]   paddr,
    input wire logic [31:0]   prdata,
    input wire logic [DW-1:0] exp_in_i,
    input wire logic [DW-1:0] exp_dir_in_i,
    input wire logic          smb_req_o,
    input wire logic [1:0]    smb_op_o,
    input wire logic [3:0]    smb_sel_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    logic rd;
    assign rd = pready && !pwrite;
    property p_reload_zero;
        rd && paddr == ioexc_pkg::INTF_OFS |-> !prdata[ioexc_pkg::RELOAD_BIT];
    endproperty
    a_reload_zero: assert property (p_reload_zero)
        else $error("reload bit read as one");
    property p_intf_rsv;
        rd && paddr == ioexc_pkg::INTF_OFS |-> prdata[30:30] == 1'h0
            && prdata[23:16] == 8'h00;
    endproperty
    a_intf_rsv: assert property (p_intf_rsv)
        else $error("interface reserved bits set");
    property p_lo_rsv;
        rd && paddr == ioexc_pkg::ADDR_LO_OFS |-> (prdata & 32'hff010101) == '0;
    endproperty
    a_lo_rsv: assert property (p_lo_rsv)
        else $error("low address reserved bits set");
    property p_hi_rsv;
        rd && paddr == ioexc_pkg::ADDR_HI_OFS |-> (prdata & 32'hffffff01) == '0;
    endproperty
    a_hi_rsv: assert property (p_hi_rsv)
        else $error("high address reserved bits set");
    property p_sel_legal;
        smb_req_o |-> smb_sel_o inside {4'h0, 4'h1, 4'h2, 4'h4};
    endproperty
    a_sel_legal: assert property (p_sel_legal)
        else $error("request for a reserved select");
    property p_req_pulse;
        smb_req_o |=> !smb_req_o;
    endproperty
    a_req_pulse: assert property (p_req_pulse)
        else $error("request longer than one cycle");
    property p_op_legal;
        smb_req_o |-> smb_op_o != 2'h3;
    endproperty
    a_op_legal: assert property (p_op_legal)
        else $error("request with unknown kind");
    property p_in_ro;
        rd && paddr == ioexc_pkg::INTF_OFS |-> ((prdata[DW-1:0]
            ^ $past(exp_in_i, 2)) & $past(exp_dir_in_i, 2)) == '0;
    endproperty
    a_in_ro: assert property (p_in_ro)
        else $error("input pin bits differ from expander");
endmodule : ioexc_properties

bind ioexc_top ioexc_properties #(.DW(DW)) u_props (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .pwrite(pwrite),
    .pready(pready), .paddr(paddr), .prdata(prdata), .exp_in_i(exp_in_i),
    .exp_dir_in_i(exp_dir_in_i), .smb_req_o(smb_req_o),
    .smb_op_o(smb_op_o), .smb_sel_o(smb_sel_o)
);

// ==== ioexc_smb_model.sv ====
// ioexc_smb_model: smbus engine stand-in that answers each request with done
// assumes one request at a time from the block; done is held two cycles
`timescale 1ns/1ps
module ioexc_smb_model (
    input  wire logic sys_clk_i,
    input  wire logic arst_n_i,
    input  wire logic req_i,
    input  wire logic slow_i,
    output logic      done_o
);
    int cnt;
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt <= 0;
            done_o <= 1'b0;
        end else begin
            // two-cycle done so the three-stage synchroniser still sees it
            if (req_i) cnt <= slow_i ? 40 : 3;
            else if (cnt != 0) cnt <= cnt - 1;
            done_o <= (cnt == 1) || (cnt == 2);
        end
    end
endmodule : ioexc_smb_model

// ==== ioexc_sync.sv ====
// ioexc_sync: three-stage synchroniser, change taken once stages 2 and 3 agree
// assumes the input is asynchronous to sys_clk_i
`timescale 1ns/1ps
module ioexc_sync (
    input  wire logic sys_clk_i,
    input  wire logic arst_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    typedef struct packed {
        logic [2:0] s;
        logic       q;
    } ioexc_sync_t;
    ioexc_sync_t st_r;
    ioexc_sync_t st_nxt;
    always_comb begin
        st_nxt   = st_r;
        st_nxt.s = {st_r.s[1:0], d_i};
        if (st_r.s[1] == st_r.s[2]) begin
            st_nxt.q = st_r.s[2];
        end
    end
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign q_o = st_r.q;
endmodule : ioexc_sync

// ==== ioexc_tb_top.sv ====
// ioexc_tb_top: self-checking bench for the expander control over apb
// assumes the smbus model answers every request it sees
`timescale 1ns/1ps
module ioexc_tb_top;
    logic        sys_clk_i, arst_n_i, psel, penable, pwrite, pready, pslverr;
    logic        smb_done_i, smb_req_o, irq_o, slow, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, w;
    logic [15:0] core_out_i, exp_in_i, exp_dir_in_i, smb_data_o, cap_data, d;
    logic [6:0]  smb_addr_o, cap_addr;
    logic [3:0]  smb_sel_o, cap_sel;
    logic [3:0]  codes [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h3, 4'h5};
    logic [1:0]  smb_op_o, cap_op;
    int          seed = 67, miscompares = 0, n_checks = 0, n_req = 0, cyc = 0;
    int          k, m;
    ioexc_top #(.DW(16)) u_dut (
        .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .core_out_i(core_out_i), .exp_in_i(exp_in_i),
        .exp_dir_in_i(exp_dir_in_i), .smb_done_i(smb_done_i),
        .smb_req_o(smb_req_o), .smb_op_o(smb_op_o), .smb_sel_o(smb_sel_o),
        .smb_addr_o(smb_addr_o), .smb_data_o(smb_data_o), .irq_o(irq_o)
    );
    ioexc_smb_model u_smb (
        .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .req_i(smb_req_o),
        .slow_i(slow), .done_o(smb_done_i)
    );
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    task wrap_up;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (smb_req_o === 1'b1) begin
            n_req <= n_req + 1;
            cap_op <= smb_op_o;
            cap_sel <= smb_sel_o;
            cap_addr <= smb_addr_o;
            cap_data <= smb_data_o;
        end
        if (cyc == 20000) begin
            miscompares = miscompares + 1;
            wrap_up();
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
        @(posedge sys_clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= v;
        exp_in_i <= $random(seed);
        @(posedge sys_clk_i);
        penable <= 1'b1;
        @(posedge sys_clk_i);
        while (pready !== 1'b1) @(posedge sys_clk_i);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task done_seen;
        k = 0;
        while (irq_o !== 1'b1 && k < 300) begin
            @(posedge sys_clk_i);
            k++;
        end
        chk({31'h0, irq_o}, 32'h1);
    endtask : done_seen
    // outputs follow the written data, input pins keep the expander state
    function logic [15:0] pins(input logic [15:0] v);
        return (v & ~exp_dir_in_i) | (exp_in_i & exp_dir_in_i);
    endfunction : pins
    function logic [31:0] outs(input logic [15:0] v);
        return {16'h0, v & ~exp_dir_in_i};
    endfunction : outs
    initial begin
        arst_n_i = 1'b0;
        {psel, penable, pwrite, slow, paddr, pwdata} = '0;
        core_out_i = $random(seed);
        exp_in_i = $random(seed);
        exp_dir_in_i = $random(seed);
        repeat (16) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        apb(1'b0, ioexc_pkg::INTF_OFS, '0);
        chk(rd & 32'hffff0000, '0);
        apb(1'b0, ioexc_pkg::ADDR_LO_OFS, '0);
        chk(rd, '0);
        apb(1'b0, ioexc_pkg::ADDR_HI_OFS, '0);
        chk(rd, '0);
        apb(1'b1, ioexc_pkg::IRQ_MSK_OFS, 32'h1);
        w = $random(seed);
        apb(1'b1, ioexc_pkg::ADDR_LO_OFS, w);
        done_seen();
        chk({30'h0, cap_op}, {30'h0, ioexc_pkg::OP_INIT});
        chk({25'h0, cap_addr}, {25'h0, w[7:1]});
        apb(1'b0, ioexc_pkg::INTF_OFS, '0);
        chk({31'h0, rd[31]}, 32'h1);
        apb(1'b1, ioexc_pkg::INTF_OFS, 32'h80000000);
        apb(1'b0, ioexc_pkg::INTF_OFS, '0);
        chk({31'h0, rd[31]}, '0);
        apb(1'b0, ioexc_pkg::ADDR_LO_OFS, '0);
        chk(rd, w & 32'h00fefefe);
        apb(1'b1, ioexc_pkg::ADDR_HI_OFS, ~w);
        apb(1'b0, ioexc_pkg::ADDR_HI_OFS, '0);
        chk(rd, ~w & 32'h000000fe);
        apb(1'b1, ioexc_pkg::IRQ_STS_OFS, 32'h1);
        for (int i = 0; i < 6; i++) begin
            m = n_req;
            slow <= i[0];
            core_out_i <= $random(seed);
            w = $random(seed);
            // data bits must be dropped outside test mode
            apb(1'b1, ioexc_pkg::INTF_OFS, {2'h0, codes[i], 10'h100, w[15:0]});
            if (i < 4) begin
                done_seen();
                chk(outs(cap_data), outs(core_out_i));
                chk({28'h0, cap_sel}, {28'h0, codes[i]});
                chk({30'h0, cap_op}, {30'h0, ioexc_pkg::OP_RELOAD});
                apb(1'b1, ioexc_pkg::IRQ_STS_OFS, 32'h1);
            end else begin
                repeat (60) @(posedge sys_clk_i);
                chk(n_req, m);
            end
        end
        apb(1'b0, ioexc_pkg::INTF_OFS, '0);
        chk(rd, {16'h1400, pins(core_out_i)});
        d = $random(seed);
        core_out_i <= ~d;
        apb(1'b1, ioexc_pkg::INTF_OFS, 32'h06000000);
        apb(1'b1, ioexc_pkg::INTF_OFS, {16'h0600, d});
        done_seen();
        chk(outs(cap_data), outs(d));
        chk({30'h0, cap_op}, {30'h0, ioexc_pkg::OP_WRITE});
        apb(1'b1, ioexc_pkg::IRQ_MSK_OFS, '0);
        repeat (3) @(posedge sys_clk_i);
        chk({31'h0, irq_o}, '0);
        apb(1'b1, ioexc_pkg::IRQ_STS_OFS, 32'h1);
        apb(1'b0, ioexc_pkg::INTF_OFS, '0);
        chk(rd, {16'h0600, pins(d)});
        apb(1'b0, 12'h364, '0);
        chk({err, rd[30:0]}, 32'h80000000);
        wrap_up();
    end
endmodule : ioexc_tb_top

// ==== ioexc_top.sv ====
// ioexc_top: control and status of the expander interface behind apb
// assumes an smbus master engine outside that takes one request at a time
// and holds smb_done_i high for two cycles or more when the transaction finishes
//
// How it works
// - test mode drives outputs from written data
// - select field picks expander 0,1,2,4
// - done flag bit 31, write-one clears
// - reload completion sets done flag
// - test-mode data write completion sets done
// - address write init completion sets done
// - addresses of expanders 0-2 held sticky
// - expander 4 address held sticky
// - data reads pin state, writes test-only
// - reload trigger launches refresh, reads zero
`timescale 1ns/1ps
module ioexc_top #(
    parameter int DW = 16
) (
    input  wire logic                 sys_clk_i,
    input  wire logic                 arst_n_i,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    input  wire logic [DW-1:0]        core_out_i,
    input  wire logic [DW-1:0]        exp_in_i,
    input  wire logic [DW-1:0]        exp_dir_in_i,
    input  wire logic                 smb_done_i,
    output logic                      smb_req_o,
    output logic [1:0]                smb_op_o,
    output logic [3:0]                smb_sel_o,
    output logic [6:0]                smb_addr_o,
    output logic [DW-1:0]             smb_data_o,
    output logic                      irq_o
);
    typedef struct packed {
        ioexc_pkg::ioexc_state_t st;
        logic                    tm;
        logic [3:0]              sel;
        logic                    done;
        logic [6:0]              a0;
        logic [6:0]              a1;
        logic [6:0]              a2;
        logic [6:0]              a4;
        logic [DW-1:0]           tdata;
        logic [DW-1:0]           pins;
        logic [1:0]              op;
        logic [3:0]              osel;
        logic                    pend_rl;
        logic                    pend_wr;
        logic                    pend_in;
        logic                    msk;
        logic                    ready;
        logic [31:0]             rdata;
        logic                    err;
        logic                    irq;
        logic                    req;
        logic [6:0]              oaddr;
        logic [DW-1:0]           odata;
    } ioexc_regs_t;

    ioexc_regs_t r_r;
    ioexc_regs_t r_nxt;
    logic        done_s;
    logic        done_q_r;

    // smbus engine sits off-chip-side, so its completion is synchronised
    ioexc_sync u_done_sync (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .d_i       (smb_done_i),
        .q_o       (done_s)
    );

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            done_q_r <= 1'b0;
        end else begin
            done_q_r <= done_s;
        end
    end

    function automatic logic sel_ok(input logic [3:0] s);
        sel_ok = (s == ioexc_pkg::SEL_E0) || (s == ioexc_pkg::SEL_E1) ||
                 (s == ioexc_pkg::SEL_E2) || (s == ioexc_pkg::SEL_E4);
    endfunction : sel_ok

    function automatic logic [6:0] addr_of(input ioexc_regs_t r,
                                           input logic [3:0] s);
        unique case (s)
            ioexc_pkg::SEL_E0: addr_of = r.a0;
            ioexc_pkg::SEL_E1: addr_of = r.a1;
            ioexc_pkg::SEL_E2: addr_of = r.a2;
            default:           addr_of = r.a4;
        endcase
    endfunction : addr_of

    logic        acc;
    logic        wr;
    logic        done_evt;
    logic [31:0] intf_rd;
    logic [DW-1:0] out_mask;

    always_comb begin
        acc      = psel && penable && !r_r.ready;
        wr       = acc && pwrite;
        done_evt = done_s && !done_q_r;
        out_mask = ~exp_dir_in_i;
        intf_rd  = '0;
        intf_rd[ioexc_pkg::DATA_LSB +: DW]      = r_r.pins;
        intf_rd[ioexc_pkg::TM_BIT]              = r_r.tm;
        intf_rd[ioexc_pkg::SEL_LSB +: ioexc_pkg::SEL_W] = r_r.sel;
        intf_rd[ioexc_pkg::DONE_BIT]            = r_r.done;
        // reload bit and reserved bits stay zero

        r_nxt       = r_r;
        r_nxt.ready = acc;
        r_nxt.err   = 1'b0;
        r_nxt.req   = 1'b0;
        // pin image: inputs from the expander, outputs from core or test data
        r_nxt.pins  = (exp_in_i & exp_dir_in_i) |
                      ((r_r.tm ? r_r.tdata : core_out_i) & out_mask);

        // completion of the outstanding transaction; set beats clear below
        unique case (r_r.st)
            ioexc_pkg::IOEXC_IDLE: begin
                if (r_r.pend_in || r_r.pend_rl || r_r.pend_wr) begin
                    if (r_r.pend_in) begin
                        r_nxt.pend_in = 1'b0;
                    end else if (r_r.pend_wr) begin
                        r_nxt.pend_wr = 1'b0;
                    end else begin
                        r_nxt.pend_rl = 1'b0;
                    end
                    // select may have moved to a reserved code while queued
                    if (sel_ok(r_r.sel)) begin
                        r_nxt.op    = r_r.pend_in ? ioexc_pkg::OP_INIT :
                                      r_r.pend_wr ? ioexc_pkg::OP_WRITE :
                                                    ioexc_pkg::OP_RELOAD;
                        r_nxt.osel  = r_r.sel;
                        r_nxt.oaddr = addr_of(r_r, r_r.sel);
                        // outside test mode the core's own outputs go out
                        r_nxt.odata = (r_r.tm ? r_r.tdata : core_out_i) &
                                      out_mask;
                        r_nxt.req   = 1'b1;
                        r_nxt.st    = ioexc_pkg::IOEXC_REQ;
                    end
                end
            end
            ioexc_pkg::IOEXC_REQ: begin
                r_nxt.st = ioexc_pkg::IOEXC_WAIT;
            end
            ioexc_pkg::IOEXC_WAIT: begin
                if (done_evt) begin
                    r_nxt.st = ioexc_pkg::IOEXC_IDLE;
                end
            end
            default: r_nxt.st = ioexc_pkg::IOEXC_IDLE;
        endcase

        r_nxt.rdata = '0;
        if (acc && !pwrite) begin
            unique case (paddr)
                ioexc_pkg::INTF_OFS:    r_nxt.rdata = intf_rd;
                ioexc_pkg::ADDR_LO_OFS: begin
                    r_nxt.rdata[ioexc_pkg::A0_LSB +: ioexc_pkg::ADDR_W] = r_r.a0;
                    r_nxt.rdata[ioexc_pkg::A1_LSB +: ioexc_pkg::ADDR_W] = r_r.a1;
                    r_nxt.rdata[ioexc_pkg::A2_LSB +: ioexc_pkg::ADDR_W] = r_r.a2;
                end
                ioexc_pkg::ADDR_HI_OFS:
                    r_nxt.rdata[ioexc_pkg::A4_LSB +: ioexc_pkg::ADDR_W] = r_r.a4;
                ioexc_pkg::IRQ_STS_OFS:
                    r_nxt.rdata[ioexc_pkg::IRQ_BIT] = r_r.done;
                ioexc_pkg::IRQ_MSK_OFS:
                    r_nxt.rdata[ioexc_pkg::IRQ_BIT] = r_r.msk;
                default:                r_nxt.err = 1'b1;
            endcase
        end

        if (wr) begin
            unique case (paddr)
                ioexc_pkg::INTF_OFS: begin
                    r_nxt.tm  = pwdata[ioexc_pkg::TM_BIT];
                    r_nxt.sel = pwdata[ioexc_pkg::SEL_LSB +:
                                       ioexc_pkg::SEL_W];
                    if (pwdata[ioexc_pkg::DONE_BIT]) begin
                        r_nxt.done = 1'b0;
                    end
                    // a reserved select code targets nothing, so no smbus work
                    if (sel_ok(r_nxt.sel)) begin
                        if (pwdata[ioexc_pkg::RELOAD_BIT]) begin
                            r_nxt.pend_rl = 1'b1;
                        end
                        // data lands only in test mode, outputs only
                        if (r_r.tm) begin
                            r_nxt.tdata = (pwdata[DW-1:0] & out_mask) |
                                          (r_r.tdata & exp_dir_in_i);
                            r_nxt.pend_wr = 1'b1;
                        end
                    end
                end
                ioexc_pkg::ADDR_LO_OFS: begin
                    r_nxt.a0 = pwdata[ioexc_pkg::A0_LSB +:
                                      ioexc_pkg::ADDR_W];
                    r_nxt.a1 = pwdata[ioexc_pkg::A1_LSB +: ioexc_pkg::ADDR_W];
                    r_nxt.a2 = pwdata[ioexc_pkg::A2_LSB +: ioexc_pkg::ADDR_W];
                    if (r_r.sel == ioexc_pkg::SEL_E0 ||
                        r_r.sel == ioexc_pkg::SEL_E1 ||
                        r_r.sel == ioexc_pkg::SEL_E2) begin
                        r_nxt.pend_in = 1'b1;
                    end
                end
                ioexc_pkg::ADDR_HI_OFS: begin
                    r_nxt.a4 = pwdata[ioexc_pkg::A4_LSB +:
                                      ioexc_pkg::ADDR_W];
                    if (r_r.sel == ioexc_pkg::SEL_E4) begin
                        r_nxt.pend_in = 1'b1;
                    end
                end
                ioexc_pkg::IRQ_STS_OFS: begin
                    if (pwdata[ioexc_pkg::IRQ_BIT]) begin
                        r_nxt.done = 1'b0;
                    end
                end
                ioexc_pkg::IRQ_MSK_OFS: r_nxt.msk = pwdata[ioexc_pkg::IRQ_BIT];
                default:                r_nxt.err = 1'b1;
            endcase
        end

        // completion only counts if the finished target is still selected
        if (r_r.st == ioexc_pkg::IOEXC_WAIT && done_evt &&
            r_r.osel == r_r.sel) begin
            r_nxt.done = 1'b1;
        end
        r_nxt.irq = r_nxt.done && r_nxt.msk;
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r_r    <= '0;
            r_r.st <= ioexc_pkg::IOEXC_IDLE;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign pready     = r_r.ready;
    assign prdata     = r_r.rdata;
    assign pslverr    = r_r.err;
    assign irq_o      = r_r.irq;
    assign smb_req_o  = r_r.req;
    assign smb_op_o   = r_r.op;
    assign smb_sel_o  = r_r.osel;
    assign smb_addr_o = r_r.oaddr;
    assign smb_data_o = r_r.odata;
endmodule : ioexc_top
